/* include/rx_acq_cfg_pkg.sv */
// register map, reset values and field positions of the acquisition config bank
// assumes 8-bit registers on a plain strobe port, one clock domain
package rx_acq_cfg_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IVAL_W = 24;
  localparam int THR_W = 12;

  // ==========================================================
  // offsets
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h00;
  localparam logic [7:0] RX_CTRL1_ADDR = 8'h02;
  localparam logic [7:0] VSB_CONTROL_ADDR = 8'h03;
  localparam logic [7:0] GAIN_CONTROL_CFG_ADDR = 8'h04;
  localparam logic [7:0] VSB_IVAL_B0_ADDR = 8'h1b;
  localparam logic [7:0] VSB_IVAL_B1_ADDR = 8'h1c;
  localparam logic [7:0] VSB_IVAL_B2_ADDR = 8'h1d;
  localparam logic [7:0] QAM_IVAL_B0_ADDR = 8'h1e;
  localparam logic [7:0] QAM_IVAL_B1_ADDR = 8'h1f;
  localparam logic [7:0] QAM_IVAL_B2_ADDR = 8'h20;
  localparam logic [7:0] THR_LO_ADDR = 8'h21;
  localparam logic [7:0] THR_HI_ADDR = 8'h22;
  localparam logic [7:0] RX_STATUS_ADDR = 8'h26;

  // ==========================================================
  // field positions
  localparam int AUTO_RESTART_DISABLE_BIT = 4;
  localparam int GAIN_OUT_INVERT_BIT = 2;
  localparam int SEG_ERR_OVER_BIT = 3;

  // ==========================================================
  // reset values, write masks and vsb mode code
  localparam logic [7:0] VSB_CONTROL_RST = 8'h02;
  localparam logic [7:0] GAIN_CONTROL_CFG_RST = 8'h07;
  localparam logic [7:0] VSB_IVAL_B0_RST = 8'hbc;
  localparam logic [7:0] VSB_IVAL_B1_RST = 8'h64;
  localparam logic [7:0] VSB_IVAL_B2_RST = 8'h00;
  localparam logic [7:0] QAM_IVAL_B0_RST = 8'h00;
  localparam logic [7:0] QAM_IVAL_B1_RST = 8'h08;
  localparam logic [7:0] QAM_IVAL_B2_RST = 8'h00;
  localparam logic [7:0] THR_LO_RST = 8'h05;
  localparam logic [7:0] THR_HI_RST = 8'h00;
  localparam logic [7:0] RX_CTRL1_RST = 8'h00;
  localparam logic [7:0] VSB_CONTROL_RMASK = 8'h1f;
  localparam logic [7:0] GAIN_CONTROL_CFG_RMASK = 8'h07;
  localparam logic [7:0] THR_HI_RMASK = 8'h0f;
  localparam logic [1:0] MODE_VSB = 2'h0;

endpackage

/* src/rx_acq_cfg_regs.sv */
// acquisition configuration registers: auto restart, gain output polarity,
// update intervals and segment error threshold with soft-reset staging
// assumes the demodulator supplies synchronous rs block and error pulses
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps

module rx_acq_cfg_regs (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [rx_acq_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rx_acq_cfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rx_acq_cfg_pkg::DATA_W-1:0] o_rdata,
  // demodulator side
  input wire logic i_rs_block,
  input wire logic i_seg_err,
  input wire logic i_gain_raw,
  output logic o_gain_control_output,
  output logic o_acq_restart,
  output logic o_soft_reset
);
  import rx_acq_cfg_pkg::*;

  // written (shadow) copies
  logic [7:0] vsb_control_reg, vsb_control_next;
  logic [7:0] gain_cfg_wr_reg, gain_cfg_wr_next;
  logic [7:0] vsb_b0_reg, vsb_b0_next;
  logic [7:0] vsb_b1_wr_reg, vsb_b1_wr_next;
  logic [7:0] vsb_b2_reg, vsb_b2_next;
  logic [7:0] qam_b0_wr_reg, qam_b0_wr_next;
  logic [7:0] qam_b1_wr_reg, qam_b1_wr_next;
  logic [7:0] qam_b2_reg, qam_b2_next;
  logic [7:0] thr_lo_wr_reg, thr_lo_wr_next;
  logic [3:0] thr_hi_wr_reg, thr_hi_wr_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  // active copies, loaded at soft reset
  logic [7:0] gain_cfg_act_reg, gain_cfg_act_next;
  logic [7:0] vsb_b1_act_reg, vsb_b1_act_next;
  logic [7:0] qam_b0_act_reg, qam_b0_act_next;
  logic [7:0] qam_b1_act_reg, qam_b1_act_next;
  logic [THR_W-1:0] thr_act_reg, thr_act_next;
  // soft reset and outputs
  logic soft_rst_reg, soft_rst_next;
  logic restart_reg, restart_next;
  logic gain_out_reg, gain_out_next;
  logic [7:0] rdata_reg, rdata_next;
  // sampled gain input
  logic gain_meta_reg, gain_sync_reg;
  // monitor
  logic [IVAL_W-1:0] interval;
  logic over;
  logic interval_end;
  logic vsb_mode;
  logic wr_soft;

  // ==========================================================
  // register writes
  always_comb begin
    vsb_control_next = vsb_control_reg;
    gain_cfg_wr_next = gain_cfg_wr_reg;
    vsb_b0_next = vsb_b0_reg;
    vsb_b1_wr_next = vsb_b1_wr_reg;
    vsb_b2_next = vsb_b2_reg;
    qam_b0_wr_next = qam_b0_wr_reg;
    qam_b1_wr_next = qam_b1_wr_reg;
    qam_b2_next = qam_b2_reg;
    thr_lo_wr_next = thr_lo_wr_reg;
    thr_hi_wr_next = thr_hi_wr_reg;
    ctrl1_next = ctrl1_reg;
    if (i_wr) begin
      unique case (i_addr)
        RX_CTRL1_ADDR: ctrl1_next = i_wdata;
        // reserved nibble is kept as written; host is expected to write 2h
        VSB_CONTROL_ADDR: vsb_control_next = i_wdata & VSB_CONTROL_RMASK;
        // host is expected to write 3h into bits 1:0
        GAIN_CONTROL_CFG_ADDR: gain_cfg_wr_next = i_wdata & GAIN_CONTROL_CFG_RMASK;
        VSB_IVAL_B0_ADDR: vsb_b0_next = i_wdata;
        VSB_IVAL_B1_ADDR: vsb_b1_wr_next = i_wdata;
        VSB_IVAL_B2_ADDR: vsb_b2_next = i_wdata;
        QAM_IVAL_B0_ADDR: qam_b0_wr_next = i_wdata;
        QAM_IVAL_B1_ADDR: qam_b1_wr_next = i_wdata;
        QAM_IVAL_B2_ADDR: qam_b2_next = i_wdata;
        THR_LO_ADDR: thr_lo_wr_next = i_wdata;
        THR_HI_ADDR: thr_hi_wr_next = i_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      vsb_control_reg <= VSB_CONTROL_RST;
      gain_cfg_wr_reg <= GAIN_CONTROL_CFG_RST;
      vsb_b0_reg <= VSB_IVAL_B0_RST;
      vsb_b1_wr_reg <= VSB_IVAL_B1_RST;
      vsb_b2_reg <= VSB_IVAL_B2_RST;
      qam_b0_wr_reg <= QAM_IVAL_B0_RST;
      qam_b1_wr_reg <= QAM_IVAL_B1_RST;
      qam_b2_reg <= QAM_IVAL_B2_RST;
      thr_lo_wr_reg <= THR_LO_RST;
      thr_hi_wr_reg <= THR_HI_RST[3:0];
      ctrl1_reg <= RX_CTRL1_RST;
    end else begin
      vsb_control_reg <= vsb_control_next;
      gain_cfg_wr_reg <= gain_cfg_wr_next;
      vsb_b0_reg <= vsb_b0_next;
      vsb_b1_wr_reg <= vsb_b1_wr_next;
      vsb_b2_reg <= vsb_b2_next;
      qam_b0_wr_reg <= qam_b0_wr_next;
      qam_b1_wr_reg <= qam_b1_wr_next;
      qam_b2_reg <= qam_b2_next;
      thr_lo_wr_reg <= thr_lo_wr_next;
      thr_hi_wr_reg <= thr_hi_wr_next;
      ctrl1_reg <= ctrl1_next;
    end
  end

  // ==========================================================
  // soft reset and auto restart
  assign wr_soft = i_wr && (i_addr == SOFT_RESET_ADDR);
  assign vsb_mode = (ctrl1_reg[1:0] == MODE_VSB);

  always_comb begin
    soft_rst_next = wr_soft;
    // an auto restart is handled like a host soft reset and also pulses o_acq_restart
    restart_next = interval_end && over && vsb_mode
                   && !vsb_control_reg[AUTO_RESTART_DISABLE_BIT];
    gain_cfg_act_next = gain_cfg_act_reg;
    vsb_b1_act_next = vsb_b1_act_reg;
    qam_b0_act_next = qam_b0_act_reg;
    qam_b1_act_next = qam_b1_act_reg;
    thr_act_next = thr_act_reg;
    if (soft_rst_reg || restart_reg) begin
      gain_cfg_act_next = gain_cfg_wr_reg;
      vsb_b1_act_next = vsb_b1_wr_reg;
      qam_b0_act_next = qam_b0_wr_reg;
      qam_b1_act_next = qam_b1_wr_reg;
      thr_act_next = {thr_hi_wr_reg, thr_lo_wr_reg};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      soft_rst_reg <= 1'b0;
      restart_reg <= 1'b0;
      gain_cfg_act_reg <= GAIN_CONTROL_CFG_RST;
      vsb_b1_act_reg <= VSB_IVAL_B1_RST;
      qam_b0_act_reg <= QAM_IVAL_B0_RST;
      qam_b1_act_reg <= QAM_IVAL_B1_RST;
      thr_act_reg <= {THR_HI_RST[3:0], THR_LO_RST};
    end else begin
      soft_rst_reg <= soft_rst_next;
      restart_reg <= restart_next;
      gain_cfg_act_reg <= gain_cfg_act_next;
      vsb_b1_act_reg <= vsb_b1_act_next;
      qam_b0_act_reg <= qam_b0_act_next;
      qam_b1_act_reg <= qam_b1_act_next;
      thr_act_reg <= thr_act_next;
    end
  end

  // ==========================================================
  // interval select and monitor
  // bytes without the soft-reset note act at once, the others use active copies
  assign interval = vsb_mode ? {vsb_b2_reg, vsb_b1_act_reg, vsb_b0_reg}
                             : {qam_b2_reg, qam_b1_act_reg, qam_b0_act_reg};

  seg_err_monitor #(
    .IVAL_W(IVAL_W),
    .THR_W(THR_W)
  ) u_mon (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_restart(soft_rst_reg || restart_reg),
    .i_interval(interval),
    .i_threshold(thr_act_reg),
    .i_rs_block(i_rs_block),
    .i_seg_err(i_seg_err),
    .o_over(over),
    .o_interval_end(interval_end)
  );

  // ==========================================================
  // gain output polarity; raw input is a pin, so it is synchronised first
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      gain_meta_reg <= 1'b0;
      gain_sync_reg <= 1'b0;
    end else begin
      gain_meta_reg <= i_gain_raw;
      gain_sync_reg <= gain_meta_reg;
    end
  end

  always_comb begin
    gain_out_next = gain_sync_reg ^ gain_cfg_act_reg[GAIN_OUT_INVERT_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      gain_out_reg <= 1'b0;
    end else begin
      gain_out_reg <= gain_out_next;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        RX_CTRL1_ADDR: rdata_next = ctrl1_reg;
        VSB_CONTROL_ADDR: rdata_next = vsb_control_reg;
        GAIN_CONTROL_CFG_ADDR: rdata_next = gain_cfg_wr_reg;
        VSB_IVAL_B0_ADDR: rdata_next = vsb_b0_reg;
        VSB_IVAL_B1_ADDR: rdata_next = vsb_b1_wr_reg;
        VSB_IVAL_B2_ADDR: rdata_next = vsb_b2_reg;
        QAM_IVAL_B0_ADDR: rdata_next = qam_b0_wr_reg;
        QAM_IVAL_B1_ADDR: rdata_next = qam_b1_wr_reg;
        QAM_IVAL_B2_ADDR: rdata_next = qam_b2_reg;
        THR_LO_ADDR: rdata_next = thr_lo_wr_reg;
        THR_HI_ADDR: rdata_next = {4'h0, thr_hi_wr_reg};
        RX_STATUS_ADDR: rdata_next = {4'h0, over, 3'h0};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_gain_control_output = gain_out_reg;
  assign o_acq_restart = restart_reg;
  assign o_soft_reset = soft_rst_reg || restart_reg;

endmodule

/* src/seg_err_monitor.sv */
// segment error counter over an update interval of rs blocks
// assumes block and error strobes are synchronous one-cycle pulses
`timescale 1ns/10ps
module seg_err_monitor #(
  parameter int IVAL_W = 24,
  parameter int THR_W = 12
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // restart of the window
  input wire logic i_restart,
  // interval and threshold
  input wire logic [IVAL_W-1:0] i_interval,
  input wire logic [THR_W-1:0] i_threshold,
  // events
  input wire logic i_rs_block,
  input wire logic i_seg_err,
  // results
  output logic o_over,
  output logic o_interval_end
);

  logic [IVAL_W-1:0] blk_cnt_reg, blk_cnt_next;
  logic [IVAL_W-1:0] err_cnt_reg, err_cnt_next;
  logic over_reg, over_next;
  logic end_reg, end_next;
  logic last_blk;
  logic [IVAL_W-1:0] err_total;

  // ==========================================================
  // interval counting and compare
  always_comb begin
    // an interval of zero is treated as one block so the window never stalls
    last_blk = i_rs_block && (blk_cnt_reg + 1'b1 >= i_interval);
    err_total = err_cnt_reg + {{(IVAL_W-1){1'b0}}, i_seg_err};
    blk_cnt_next = blk_cnt_reg;
    err_cnt_next = err_total;
    over_next = over_reg;
    end_next = 1'b0;
    if (i_restart) begin
      blk_cnt_next = '0;
      err_cnt_next = '0;
    end else if (last_blk) begin
      blk_cnt_next = '0;
      err_cnt_next = '0;
      over_next = err_total > {{(IVAL_W-THR_W){1'b0}}, i_threshold};
      end_next = 1'b1;
    end else if (i_rs_block) begin
      blk_cnt_next = blk_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      blk_cnt_reg <= '0;
      err_cnt_reg <= '0;
      over_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      blk_cnt_reg <= blk_cnt_next;
      err_cnt_reg <= err_cnt_next;
      over_reg <= over_next;
      end_reg <= end_next;
    end
  end

  assign o_over = over_reg;
  assign o_interval_end = end_reg;

endmodule

/* tb/rx_acq_cfg_regs_chk.sv */
// port assertions for the acquisition config bank
// assumes it is bound onto rx_acq_cfg_regs, one clock domain
`timescale 1ns/10ps
module rx_acq_cfg_regs_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [rx_acq_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rx_acq_cfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [rx_acq_cfg_pkg::DATA_W-1:0] o_rdata,
  // demodulator side
  input wire logic i_rs_block,
  input wire logic i_gain_raw,
  input wire logic o_gain_control_output,
  input wire logic o_acq_restart,
  input wire logic o_soft_reset
);
  import rx_acq_cfg_pkg::*;
  // =====================================
  // clocking
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // =====================================
  // mirror of the restart disable bit as last written by the host
  logic dis_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      dis_reg <= 1'b0;
    end else if (i_wr && i_addr == VSB_CONTROL_ADDR) begin
      dis_reg <= i_wdata[AUTO_RESTART_DISABLE_BIT];
    end
  end
  // =====================================
  // sequences and properties
  sequence s_soft_wr;
    i_wr && i_addr == 8'h00;
  endsequence
  // raw pin steady, no staged values landing, pipeline not just out of reset
  sequence s_quiet;
    (!i_sys_rst && $stable(i_gain_raw) && !o_soft_reset)[*5];
  endsequence
  property p_soft_pulse;
    s_soft_wr |=> o_soft_reset;
  endproperty
  property p_soft_cause;
    o_soft_reset |-> $past(i_wr) && $past(i_addr) == 8'h00 || o_acq_restart;
  endproperty
  property p_restart_soft;
    o_acq_restart |-> o_soft_reset && !$past(dis_reg);
  endproperty
  property p_restart_block;
    o_acq_restart |-> $past(i_rs_block) || $past(i_rs_block, 2) || $past(i_rs_block, 3);
  endproperty
  property p_restart_single;
    o_acq_restart |=> !o_acq_restart;
  endproperty
  property p_rd_vsb_ctl;
    i_rd && i_addr == 8'h03 |=> o_rdata[7:5] == 3'h0;
  endproperty
  property p_rd_gain;
    i_rd && i_addr == 8'h04 |=> o_rdata[7:3] == 5'h00;
  endproperty
  property p_gain_const;
    s_quiet |-> $stable(o_gain_control_output);
  endproperty
  // =====================================
  // assertions
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("no soft reset pulse after write to 00h");
  a_soft_cause: assert property (p_soft_cause)
    else $error("soft reset pulse without cause");
  a_restart_soft: assert property (p_restart_soft)
    else $error("auto restart without soft reset or while disabled");
  a_restart_block: assert property (p_restart_block)
    else $error("auto restart not at interval end");
  a_restart_single: assert property (p_restart_single)
    else $error("auto restart longer than one cycle");
  a_rd_vsb_ctl: assert property (p_rd_vsb_ctl)
    else $error("vsb control reserved bits not zero");
  a_rd_gain: assert property (p_rd_gain)
    else $error("gain control reserved bits not zero");
  a_gain_const: assert property (p_gain_const)
    else $error("gain output moved without soft reset");
endmodule

/* tb/tb_rx_acq_cfg_regs.sv */
// self-checking bench for the acquisition config bank
// assumes the checker file is compiled ahead of this one
`timescale 1ns/10ps
module tb_rx_acq_cfg_regs;
  import rx_acq_cfg_pkg::*;
  logic i_core_clk, i_sys_rst, i_wr, i_rd, i_rs_block, i_seg_err, i_gain_raw;
  logic [7:0] i_addr, i_wdata, o_rdata, v;
  logic o_gain_control_output, o_acq_restart, o_soft_reset;
  int fail_count = 0;
  int samples_checked = 0;
  int n_rst = 0;
  int n0;
  // rows: write flag, address, write data or expected read
  // writes keep 03h low nibble at 2h and 04h bits 1:0 at 3h
  logic [16:0] rows [0:33] = '{
    17'h00302, 17'h00407, 17'h01bbc, 17'h01c64, 17'h01d00, // reset values
    17'h01e00, 17'h01f08, 17'h02000, 17'h02105, 17'h02200, 17'h01000,
    17'h103f2, 17'h00312, 17'h10302, 17'h00302, 17'h104fb, 17'h00403,
    17'h11b04, 17'h01b04, 17'h11c00, 17'h01c00, 17'h11d5a, 17'h01d5a,
    17'h11d00, 17'h11e11, 17'h01e11, 17'h11f22, 17'h01f22, 17'h12033,
    17'h02033, 17'h12101, 17'h02101, 17'h122f0, 17'h02200};
  // restart cases: control, mode, blocks, errors, restarts, status
  logic [7:0] acase [0:5][0:5] = '{
    '{8'h02, 8'h00, 8'h04, 8'h02, 8'h01, 8'h08},
    '{8'h02, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00},
    '{8'h12, 8'h00, 8'h04, 8'h03, 8'h00, 8'h08},
    '{8'h02, 8'h00, 8'h04, 8'h02, 8'h01, 8'h08},
    '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00},
    '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h08}};
  rx_acq_cfg_regs u_rx_acq_cfg_regs (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rs_block(i_rs_block), .i_seg_err(i_seg_err), .i_gain_raw(i_gain_raw),
    .o_gain_control_output(o_gain_control_output), .o_acq_restart(o_acq_restart),
    .o_soft_reset(o_soft_reset));
  // clock and restart counter
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (o_acq_restart === 1'b1) n_rst <= n_rst + 1;
  end
  // =====================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  // read data only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard
  initial begin
    #1ms;
    fail_count++;
    wrap_up();
  end
  // =====================================
  // main sequence
  initial begin
    {i_sys_rst, i_wr, i_rd, i_rs_block, i_seg_err, i_gain_raw} = 6'h20;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
      else begin
        rd(rows[i][15:8], v);
        chk(v, rows[i][7:0]);
      end
    end
    $display("register table test done");
    // staged clear of the invert must wait for soft reset
    chk({7'h00, o_gain_control_output}, 8'h01);
    @(posedge i_core_clk);
    i_gain_raw <= 1'b1;
    idle(6);
    chk({7'h00, o_gain_control_output}, 8'h00);
    wr(8'h00, 8'h00);
    #1 chk({7'h00, o_soft_reset}, 8'h01);
    idle(6);
    chk({7'h00, o_gain_control_output}, 8'h01);
    $display("gain polarity test done");
    // vsb interval 4 and qam interval 2 blocks, threshold 1, made active first
    wr(8'h1e, 8'h02);
    wr(8'h1f, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h00, 8'h00);
    // staged invert that only an auto restart can bring in
    wr(8'h04, 8'h07);
    foreach (acase[k]) begin
      wr(8'h03, acase[k][0]);
      wr(8'h02, acase[k][1]);
      n0 = n_rst;
      for (int j = 0; j < acase[k][2]; j++) begin
        @(posedge i_core_clk);
        i_rs_block <= 1'b1;
        i_seg_err <= (j < acase[k][3]);
      end
      @(posedge i_core_clk);
      i_rs_block <= 1'b0;
      i_seg_err <= 1'b0;
      idle(8);
      chk(8'(n_rst - n0), acase[k][4]);
      rd(8'h26, v);
      chk(v & 8'h08, acase[k][5]);
    end
    // raw high and invert now active, so the output reads low
    chk({7'h00, o_gain_control_output}, 8'h00);
    wr(8'h04, 8'h03);
    $display("auto restart test done");
    // reset in mid-run restores defaults
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(8'h04, v);
    chk(v, 8'h07);
    rd(8'h1c, v);
    chk(v, 8'h64);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule

bind rx_acq_cfg_regs rx_acq_cfg_regs_chk u_rx_acq_cfg_regs_chk (.i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_rs_block(i_rs_block), .i_gain_raw(i_gain_raw),
  .o_gain_control_output(o_gain_control_output), .o_acq_restart(o_acq_restart),
  .o_soft_reset(o_soft_reset));
